// ==== design/msv_pkg.sv ====
/*
 * constants for the minimal system voltage register bank: offsets, fields,
 * code limits and the power-on defaults per battery cell count.
 * assumes the cell count arrives as a two-bit code from the pin sense stage.
 */
// Overview of operation
// R1: a field value only means something inside its valid range
// R2: clamped-low field drops writes below its range minimum, old value kept
// R3: clamped-high field drops writes above its range maximum, old value kept
// R4: at power-on the cell-config pin sense gives the cell count default
// R5: default minimal system voltage 3.5 V, 7 V, 9 V, 12 V for 1 to 4 cells
// R6: 6-bit code in bits 5:0, 2500 mV plus code times 250 mV, up to 16000 mV
// R7: minimal system voltage field is clamped high at 16000 mV
// R8: register-reset command restores pin-derived default, reserved bits to zero
package msv_pkg;
   // register offsets
   localparam logic [7:0] MSV_OFS_MIN_SYS = 8'h00;
   localparam logic [7:0] MSV_OFS_CEILING = 8'h01;
   // minimal system voltage field layout
   localparam int MSV_MIN_SYS_LSB = 0;
   localparam int MSV_MIN_SYS_W = 6;
   localparam int MSV_MIN_RSV_LSB = 6;
   localparam int MSV_MIN_RSV_W = 2;
   localparam logic [1:0] MSV_MIN_RSV_RST = 2'h0;
   // minimal system voltage encoding in mV
   localparam int MSV_MIN_OFFSET_MV = 2500;
   localparam int MSV_MIN_STEP_MV = 250;
   localparam int MSV_MIN_MAX_MV = 16000;
   localparam logic [5:0] MSV_MIN_MAX_CODE =
      6'((MSV_MIN_MAX_MV - MSV_MIN_OFFSET_MV) / MSV_MIN_STEP_MV);
   // minimal system voltage defaults per cell count in mV
   localparam int MSV_MIN_DEF_1S_MV = 3500;
   localparam int MSV_MIN_DEF_2S_MV = 7000;
   localparam int MSV_MIN_DEF_3S_MV = 9000;
   localparam int MSV_MIN_DEF_4S_MV = 12000;
   // charge voltage ceiling field layout and encoding
   localparam int MSV_CEIL_LSB = 0;
   localparam int MSV_CEIL_W = 11;
   localparam int MSV_CEIL_STEP_MV = 10;
   localparam int MSV_CEIL_MIN_MV = 3000;
   localparam logic [10:0] MSV_CEIL_MIN_CODE = 11'(MSV_CEIL_MIN_MV / MSV_CEIL_STEP_MV);
   localparam int MSV_CEIL_DEF_1S_MV = 4200;
   localparam int MSV_CEIL_DEF_2S_MV = 8400;
   localparam int MSV_CEIL_DEF_3S_MV = 12600;
   localparam int MSV_CEIL_DEF_4S_MV = 16800;
   // cell count codes from the pin sense
   localparam logic [1:0] MSV_CELL_1S = 2'h0;
   localparam logic [1:0] MSV_CELL_2S = 2'h1;
   localparam logic [1:0] MSV_CELL_3S = 2'h2;
   localparam logic [1:0] MSV_CELL_4S = 2'h3;
   // synchroniser depth and data width of the register port
   localparam int MSV_SYNC_STAGES = 2;
   localparam int MSV_DATA_W = 16;
   localparam logic [5:0] MSV_MIN_RST_CODE = 6'h00;
   localparam logic [10:0] MSV_CEIL_RST_CODE = 11'h000;
endpackage : msv_pkg

// ==== design/msv_sync.sv ====
/*
 * two-flop synchroniser for levels arriving from outside the clock domain.
 * assumes an active-low asynchronous reset already in this clock domain.
 */
`timescale 1ns/1ps
module msv_sync
   import msv_pkg::*;
#(
   parameter int WIDTH = 2
)
(
   input wire logic sys_clk_in,
   input wire logic rstn_in,
   input wire logic [WIDTH-1:0] async_in,
   output logic [WIDTH-1:0] sync_out
);
   logic [WIDTH-1:0] meta_q;
   logic [WIDTH-1:0] sync_q;

   // elaboration check on the width
   if (WIDTH < 1)
   begin : g_bad_width
      $error("msv_sync: WIDTH must be at least 1");
   end

   // first stage feeds only the second
   always_ff @(posedge sys_clk_in or negedge rstn_in)
   begin
      if (!rstn_in)
      begin
         meta_q <= '0;
         sync_q <= '0;
      end
      else
      begin
         meta_q <= async_in;
         sync_q <= meta_q;
      end
   end

   assign sync_out = sync_q;
endmodule : msv_sync

// ==== design/msv_regs.sv ====
/*
 * minimal system voltage register bank with charge voltage ceiling register.
 * assumes a single-cycle register port from the host interface engine and a
 * two-bit cell count level from the cell-config pin sense, on another domain.
 */
`timescale 1ns/1ps
module msv_regs
   import msv_pkg::*;
(
   input wire logic sys_clk_in,
   input wire logic rstn_in,
   input wire logic [1:0] cell_config_pin_in,
   input wire logic reg_wr_in,
   input wire logic reg_rd_in,
   input wire logic [7:0] reg_addr_in,
   input wire logic [MSV_DATA_W-1:0] reg_wdata_in,
   input wire logic reg_rst_cmd_in,
   output logic [MSV_DATA_W-1:0] reg_rdata_out,
   output logic [5:0] min_system_voltage_code_out,
   output logic [10:0] charge_voltage_ceiling_code_out,
   output logic [1:0] cell_count_out,
   output logic defaults_loaded_out
);
   logic rst_meta_q;
   logic rst_sync_q;
   logic [1:0] cell_sync;
   logic [MSV_SYNC_STAGES-1:0] load_wait_q;
   logic loaded_q;
   logic [1:0] cell_q;
   logic [5:0] min_code_q;
   logic [5:0] min_code_d;
   logic [1:0] min_rsv_q;
   logic [1:0] min_rsv_d;
   logic [10:0] ceil_code_q;
   logic [10:0] ceil_code_d;
   logic [MSV_DATA_W-1:0] rdata_q;
   logic [MSV_DATA_W-1:0] rdata_d;

   // the load wait must cover both synchroniser flops
   if (MSV_SYNC_STAGES < 2)
   begin : g_bad_stages
      $error("msv_regs: MSV_SYNC_STAGES must be at least 2");
   end

   // default minimal system voltage code for a cell count
   function automatic logic [5:0] min_default(input logic [1:0] cells);
      int mv;
      mv = MSV_MIN_DEF_1S_MV;
      unique case (cells)
         MSV_CELL_1S: mv = MSV_MIN_DEF_1S_MV;
         MSV_CELL_2S: mv = MSV_MIN_DEF_2S_MV;
         MSV_CELL_3S: mv = MSV_MIN_DEF_3S_MV;
         MSV_CELL_4S: mv = MSV_MIN_DEF_4S_MV;
      endcase
      return 6'((mv - MSV_MIN_OFFSET_MV) / MSV_MIN_STEP_MV);
   endfunction : min_default

   // default charge voltage ceiling code for a cell count
   function automatic logic [10:0] ceil_default(input logic [1:0] cells);
      int mv;
      mv = MSV_CEIL_DEF_1S_MV;
      unique case (cells)
         MSV_CELL_1S: mv = MSV_CEIL_DEF_1S_MV;
         MSV_CELL_2S: mv = MSV_CEIL_DEF_2S_MV;
         MSV_CELL_3S: mv = MSV_CEIL_DEF_3S_MV;
         MSV_CELL_4S: mv = MSV_CEIL_DEF_4S_MV;
      endcase
      return 11'(mv / MSV_CEIL_STEP_MV);
   endfunction : ceil_default

   // reset release through two flops
   always_ff @(posedge sys_clk_in or negedge rstn_in)
   begin
      if (!rstn_in)
      begin
         rst_meta_q <= 1'b0;
         rst_sync_q <= 1'b0;
      end
      else
      begin
         rst_meta_q <= 1'b1;
         rst_sync_q <= rst_meta_q;
      end
   end

   // cell-config pin sense into this domain
   msv_sync #(
      .WIDTH(2)
   ) u_cell_sync (
      .sys_clk_in(sys_clk_in),
      .rstn_in(rst_sync_q),
      .async_in(cell_config_pin_in),
      .sync_out(cell_sync)
   );

   // write decode and range checks
   wire wr_min = reg_wr_in && loaded_q && (reg_addr_in == MSV_OFS_MIN_SYS);
   wire wr_ceil = reg_wr_in && loaded_q && (reg_addr_in == MSV_OFS_CEILING);
   wire [5:0] wr_min_code = reg_wdata_in[MSV_MIN_SYS_LSB +: MSV_MIN_SYS_W];
   wire [1:0] wr_min_rsv = reg_wdata_in[MSV_MIN_RSV_LSB +: MSV_MIN_RSV_W];
   wire [10:0] wr_ceil_code = reg_wdata_in[MSV_CEIL_LSB +: MSV_CEIL_W];
   wire min_above = wr_min_code > MSV_MIN_MAX_CODE; // [R3] [R7]
   wire ceil_below = wr_ceil_code < MSV_CEIL_MIN_CODE; // [R2]
   wire cmd_rst = reg_rst_cmd_in && loaded_q;
   wire addr_mapped = (reg_addr_in == MSV_OFS_MIN_SYS) || (reg_addr_in == MSV_OFS_CEILING);
   // pin is sampled once, after the synchroniser has filled
   // sampling any earlier would catch the synchroniser's reset value
   wire load_now = load_wait_q[MSV_SYNC_STAGES-1] && !loaded_q; // [R4]

   // next register values: load, then command reset, then host write
   assign min_code_d = (load_now || cmd_rst) ? min_default(load_now ? cell_sync : cell_q) // [R5] [R8]
      : (wr_min && !min_above) ? wr_min_code // [R6] [R7]
      : min_code_q;
   assign min_rsv_d = (load_now || cmd_rst) ? MSV_MIN_RSV_RST // [R8]
      : (wr_min && !min_above) ? wr_min_rsv
      : min_rsv_q;
   assign ceil_code_d = (load_now || cmd_rst) ? ceil_default(load_now ? cell_sync : cell_q)
      : (wr_ceil && !ceil_below) ? wr_ceil_code // [R2]
      : ceil_code_q;

   // read mux, unmapped offsets read zero
   assign rdata_d = !reg_rd_in ? rdata_q
      : (reg_addr_in == MSV_OFS_MIN_SYS) ? MSV_DATA_W'({min_rsv_q, min_code_q})
      : (reg_addr_in == MSV_OFS_CEILING) ? MSV_DATA_W'(ceil_code_q)
      : '0;

   // power-on strap capture sequence
   always_ff @(posedge sys_clk_in or negedge rst_sync_q)
   begin
      if (!rst_sync_q)
      begin
         load_wait_q <= '0;
         loaded_q <= 1'b0;
         cell_q <= MSV_CELL_1S;
      end
      else
      begin
         load_wait_q <= {load_wait_q[MSV_SYNC_STAGES-2:0], 1'b1}; // [R4]
         loaded_q <= loaded_q || load_now;
         cell_q <= load_now ? cell_sync : cell_q; // [R4]
      end
   end

   // register file
   always_ff @(posedge sys_clk_in or negedge rst_sync_q)
   begin
      if (!rst_sync_q)
      begin
         min_code_q <= MSV_MIN_RST_CODE;
         min_rsv_q <= MSV_MIN_RSV_RST;
         ceil_code_q <= MSV_CEIL_RST_CODE;
         rdata_q <= '0;
      end
      else
      begin
         min_code_q <= min_code_d;
         min_rsv_q <= min_rsv_d;
         ceil_code_q <= ceil_code_d;
         rdata_q <= rdata_d;
      end
   end

   assign reg_rdata_out = rdata_q;
   assign min_system_voltage_code_out = min_code_q;
   assign charge_voltage_ceiling_code_out = ceil_code_q;
   assign cell_count_out = cell_q;
   assign defaults_loaded_out = loaded_q;

   // checks on the register behaviour
   chk_high_ignore: assert property (@(posedge sys_clk_in) disable iff (!rst_sync_q) // [R3] [R7]
      (wr_min && min_above && !cmd_rst) |=> $stable(min_code_q) && $stable(min_rsv_q))
      else $error("out of range minimal system voltage write was stored");
   chk_valid_write: assert property (@(posedge sys_clk_in) disable iff (!rst_sync_q) // [R6]
      (wr_min && !min_above && !cmd_rst) |=> (min_code_q == $past(wr_min_code)))
      else $error("in range minimal system voltage write was lost");
   chk_clamp_low: assert property (@(posedge sys_clk_in) disable iff (!rst_sync_q) // [R2]
      (wr_ceil && ceil_below && !cmd_rst) |=> $stable(ceil_code_q))
      else $error("charge ceiling write below range was stored");
   chk_default_load: assert property (@(posedge sys_clk_in) disable iff (!rst_sync_q) // [R4] [R5]
      load_now |=> loaded_q && (min_code_q == min_default(cell_q))
         && (cell_q == $past(cell_sync)))
      else $error("power-on default does not follow the cell count");
   chk_cmd_restore: assert property (@(posedge sys_clk_in) disable iff (!rst_sync_q) // [R8]
      cmd_rst |=> (min_code_q == min_default(cell_q)) && (min_rsv_q == MSV_MIN_RSV_RST)
         && (ceil_code_q == ceil_default(cell_q)))
      else $error("register reset command did not restore defaults");
   chk_min_range: assert property (@(posedge sys_clk_in) disable iff (!rst_sync_q) // [R1]
      loaded_q |-> (min_code_q <= MSV_MIN_MAX_CODE))
      else $error("minimal system voltage code left its valid range");
   chk_ceil_range: assert property (@(posedge sys_clk_in) disable iff (!rst_sync_q) // [R1]
      loaded_q |-> (ceil_code_q >= MSV_CEIL_MIN_CODE))
      else $error("charge ceiling code left its valid range");
   chk_read_back: assert property (@(posedge sys_clk_in) disable iff (!rst_sync_q)
      (reg_rd_in && (reg_addr_in == MSV_OFS_MIN_SYS))
         |=> (reg_rdata_out == MSV_DATA_W'({$past(min_rsv_q), $past(min_code_q)})))
      else $error("minimal system voltage read back wrong");
   chk_load_once: assert property (@(posedge sys_clk_in) disable iff (!rst_sync_q) // [R4]
      loaded_q |=> $stable(cell_q))
      else $error("cell count changed after power-on capture");

   // checks on early writes, in-range ceiling and reserved-bit writes, unmapped offsets and read data
   chk_early_write: assert property (@(posedge sys_clk_in) disable iff (!rst_sync_q) // [R4]
      (reg_wr_in && !loaded_q && !load_now) |=> $stable(min_code_q) && $stable(ceil_code_q))
      else $error("write before defaults loaded was stored");
   chk_ceil_write: assert property (@(posedge sys_clk_in) disable iff (!rst_sync_q) // [R2]
      (wr_ceil && !ceil_below && !cmd_rst) |=> (ceil_code_q == $past(wr_ceil_code)))
      else $error("in range charge ceiling write was lost");
   chk_rsv_write: assert property (@(posedge sys_clk_in) disable iff (!rst_sync_q)
      (wr_min && !min_above && !cmd_rst) |=> (min_rsv_q == $past(wr_min_rsv)))
      else $error("reserved bits of a good write were lost");
   chk_unmapped_write: assert property (@(posedge sys_clk_in) disable iff (!rst_sync_q) // [R1]
      (reg_wr_in && !addr_mapped && !cmd_rst && !load_now)
         |=> $stable(min_code_q) && $stable(ceil_code_q))
      else $error("write to an unmapped offset changed a register");
   chk_unmapped_read: assert property (@(posedge sys_clk_in) disable iff (!rst_sync_q) // [R1]
      (reg_rd_in && !addr_mapped) |=> (reg_rdata_out == '0))
      else $error("read of an unmapped offset returned nonzero");
   chk_rdata_hold: assert property (@(posedge sys_clk_in) disable iff (!rst_sync_q)
      !reg_rd_in |=> $stable(reg_rdata_out))
      else $error("read data changed without a read");
   cov_high_write: cover property (@(posedge sys_clk_in) disable iff (!rst_sync_q)
      wr_min && min_above);
   cov_good_write: cover property (@(posedge sys_clk_in) disable iff (!rst_sync_q)
      wr_min && !min_above ##1 cmd_rst);
   cov_low_write: cover property (@(posedge sys_clk_in) disable iff (!rst_sync_q)
      wr_ceil && ceil_below);
   cov_four_cell: cover property (@(posedge sys_clk_in) disable iff (!rst_sync_q)
      load_now && (cell_sync == MSV_CELL_4S));
   cov_cmd_over: cover property (@(posedge sys_clk_in) disable iff (!rst_sync_q)
      cmd_rst && wr_min);
endmodule : msv_regs

// ==== test/msv_host.sv ====
/*
 * host controller model driving the register port of the voltage bank.
 * assumes the bench calls access once per request, before or after defaults load.
 */
`timescale 1ns/1ps
module msv_host
   import msv_pkg::*;
(
   input wire logic sys_clk_in,
   input wire logic [MSV_DATA_W-1:0] reg_rdata_in,
   output logic reg_wr_out,
   output logic reg_rd_out,
   output logic [7:0] reg_addr_out,
   output logic [MSV_DATA_W-1:0] reg_wdata_out,
   output logic reg_rst_cmd_out
);
   // idle: strobes low, address and data parked on a junk pattern
   initial
   begin
      reg_wr_out = 1'b0;
      reg_rd_out = 1'b0;
      reg_rst_cmd_out = 1'b0;
      reg_addr_out = 8'hA5;
      reg_wdata_out = 16'h5A5A;
   end
   // one single-cycle request, taken at the second edge
   task automatic access(input logic wr, input logic rd, input logic rc,
      input logic [7:0] a, input logic [MSV_DATA_W-1:0] d);
      @(posedge sys_clk_in);
      reg_wr_out <= wr;
      reg_rd_out <= rd;
      reg_rst_cmd_out <= rc;
      reg_addr_out <= a;
      reg_wdata_out <= d;
      @(posedge sys_clk_in);
      reg_wr_out <= 1'b0;
      reg_rd_out <= 1'b0;
      reg_rst_cmd_out <= 1'b0;
      reg_addr_out <= ~a; // stale address never looks valid
      reg_wdata_out <= ~d; // stale data never looks valid
   endtask : access
endmodule : msv_host

// ==== test/tb.sv ====
/*
 * self-checking bench for the minimal system voltage register bank.
 * assumes the host model for bus cycles; cell count changes only in reset.
 */
`timescale 1ns/1ps
module tb
   import msv_pkg::*;
;
   logic sys_clk;
   logic rstn;
   logic [1:0] pin;
   logic wr, rd, rc;
   logic [7:0] addr;
   logic [15:0] wdata, rdata;
   logic [5:0] min_code;
   logic [10:0] ceil_code;
   logic [1:0] cell_cnt;
   logic loaded;
   int errors = 0;
   int checked = 0;
   // clock and time-zero inputs
   initial
   begin
      rstn = 1'b0;
      pin = 2'h0;
      sys_clk = 1'b0;
      forever #2 sys_clk = ~sys_clk;
   end
   msv_host host (.sys_clk_in(sys_clk), .reg_rdata_in(rdata), .reg_wr_out(wr),
      .reg_rd_out(rd), .reg_addr_out(addr), .reg_wdata_out(wdata), .reg_rst_cmd_out(rc));
   msv_regs dut (.sys_clk_in(sys_clk), .rstn_in(rstn), .cell_config_pin_in(pin),
      .reg_wr_in(wr), .reg_rd_in(rd), .reg_addr_in(addr), .reg_wdata_in(wdata),
      .reg_rst_cmd_in(rc), .reg_rdata_out(rdata), .min_system_voltage_code_out(min_code),
      .charge_voltage_ceiling_code_out(ceil_code), .cell_count_out(cell_cnt),
      .defaults_loaded_out(loaded));
   task automatic give_verdict;
      $display("errors=%0d checked=%0d", errors, checked);
      if (errors == 0 && checked > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask : give_verdict
   task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
      checked++;
      if (got !== exp)
      begin
         errors++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : cmp
   // write, then let the edge's updates land
   task automatic wr_reg(input logic [7:0] a, input logic [15:0] d);
      host.access(1'b1, 1'b0, 1'b0, a, d);
      #1;
   endtask : wr_reg
   task automatic rd_reg(input logic [7:0] a, input logic [15:0] exp);
      host.access(1'b0, 1'b1, 1'b0, a, 16'h0000);
      #1;
      cmp(rdata, exp);
   endtask : rd_reg
   // reset with a given cell count, bounded wait for defaults
   task automatic do_reset(input logic [1:0] c);
      @(posedge sys_clk);
      rstn <= 1'b0;
      pin <= c;
      repeat (4) @(posedge sys_clk);
      rstn <= 1'b1;
      @(posedge sys_clk);
      // a write while defaults are still loading must be dropped
      host.access(1'b1, 1'b0, 1'b0, MSV_OFS_MIN_SYS, 16'h0011);
      for (int i = 0; i < 20 && loaded !== 1'b1; i++)
         @(posedge sys_clk);
      #1;
   endtask : do_reset
   // defaults per cell count, reset command and its priority over a write
   task automatic t_defaults;
      int dmin[4];
      int dcl[4];
      logic [15:0] em;
      dmin = '{MSV_MIN_DEF_1S_MV, MSV_MIN_DEF_2S_MV, MSV_MIN_DEF_3S_MV, MSV_MIN_DEF_4S_MV};
      dcl = '{MSV_CEIL_DEF_1S_MV, MSV_CEIL_DEF_2S_MV, MSV_CEIL_DEF_3S_MV, MSV_CEIL_DEF_4S_MV};
      for (int c = 0; c < 4; c++)
      begin
         do_reset(2'(c));
         em = 16'((dmin[c] - MSV_MIN_OFFSET_MV) / MSV_MIN_STEP_MV);
         cmp(16'(cell_cnt), 16'(c));
         cmp(16'(loaded), 16'h0001);
         cmp(16'(min_code), em);
         cmp(16'(ceil_code), 16'(dcl[c] / MSV_CEIL_STEP_MV));
         wr_reg(MSV_OFS_MIN_SYS, 16'h00C5);
         cmp(16'(min_code), 16'h0005);
         host.access(1'b1, 1'b0, 1'b1, MSV_OFS_MIN_SYS, 16'h0011);
         #1;
         cmp(16'(min_code), em);
         rd_reg(MSV_OFS_MIN_SYS, em);
      end
   endtask : t_defaults
   // upper clamp of the voltage code and both ends of its range
   task automatic t_clamp;
      wr_reg(MSV_OFS_MIN_SYS, 16'h00F6);
      cmp(16'(min_code), 16'h0036);
      rd_reg(MSV_OFS_MIN_SYS, 16'h00F6);
      wr_reg(MSV_OFS_MIN_SYS, 16'h0037);
      cmp(16'(min_code), 16'h0036);
      wr_reg(MSV_OFS_MIN_SYS, 16'h003F);
      rd_reg(MSV_OFS_MIN_SYS, 16'h00F6);
      wr_reg(MSV_OFS_MIN_SYS, 16'h0080);
      rd_reg(MSV_OFS_MIN_SYS, 16'h0080);
   endtask : t_clamp
   // lower clamp on the ceiling field, reserved bits read zero
   task automatic t_ceiling;
      wr_reg(MSV_OFS_CEILING, 16'h012C);
      cmp(16'(ceil_code), 16'h012C);
      wr_reg(MSV_OFS_CEILING, 16'h012B);
      cmp(16'(ceil_code), 16'h012C);
      wr_reg(MSV_OFS_CEILING, 16'hFFFF);
      rd_reg(MSV_OFS_CEILING, 16'h07FF);
   endtask : t_ceiling
   // unmapped offset: write dropped, read zero
   task automatic t_unmapped;
      wr_reg(8'h05, 16'h0001);
      cmp(16'(min_code), 16'h0000);
      rd_reg(8'h05, 16'h0000);
   endtask : t_unmapped
   // main sequence
   initial
   begin
      t_defaults();
      t_clamp();
      t_ceiling();
      t_unmapped();
      give_verdict();
   end
   // watchdog well past the expected hundred or so cycles
   initial
   begin
      #200000;
      errors++;
      give_verdict();
   end
endmodule : tb
